// ---- core/apl_map.svh ----
`ifndef APL_MAP_SVH
`define APL_MAP_SVH

// Word indices on the bus; byte address is four times the index
`define APL_IDX_SET    6'h00
`define APL_IDX_CLEAR  6'h01
`define APL_IDX_TOGGLE 6'h02
`define APL_IDX_DIR    6'h03
`define APL_IDX_LATCH  6'h04
`define APL_IDX_PROT   6'h05
`define APL_IDX_SEL0   6'h08
`define APL_IDX_SEL1   6'h09
`define APL_IDX_SEL2   6'h0A

`define APL_PIN_W      15
`define APL_PIN_MASK   15'h5454
`define APL_PIN_RST    15'h0000
`define APL_SEL_W      5
`define APL_SEL_N      3
`define APL_SEL_RST    5'h00
`define APL_PROT_BIT   0
`define APL_WORD_ZERO  32'h0000_0000
`define APL_LANE_W     8

`endif

// ---- core/apl_pkg.sv ----
`include "apl_map.svh"

package apl_pkg;

  typedef enum logic [1:0] {
    APL_BUS_IDLE = 2'b01,
    APL_BUS_ACK  = 2'b10
  } apl_bus_state_t;

  typedef logic [`APL_PIN_W-1:0] apl_pins_t;
  typedef logic [`APL_SEL_W-1:0] apl_sel_t;

endpackage : apl_pkg

// ---- core/apl_core_if.sv ----
`include "apl_map.svh"

interface apl_core_if;
  apl_pkg::apl_pins_t                   setBits;
  apl_pkg::apl_pins_t                   clearBits;
  apl_pkg::apl_pins_t                   toggleBits;
  apl_pkg::apl_pins_t                   dir;
  apl_pkg::apl_pins_t                   latch;
  logic [`APL_SEL_N-1:0]                selWr;
  apl_pkg::apl_sel_t                    selData;
  logic [`APL_SEL_N-1:0][`APL_SEL_W-1:0] selVal;

  modport ctrl (
    output setBits, clearBits, toggleBits, dir, selWr, selData,
    input  latch, selVal
  );
  modport bank (
    input  setBits, clearBits, toggleBits, dir,
    output latch
  );
  modport sel (
    input  selWr, selData,
    output selVal
  );
endinterface : apl_core_if

// ---- core/apl_pin_latch.sv ----
`include "apl_map.svh"

module apl_pin_latch (
  input  wire logic clk_sys,
  input  wire logic rst_b,
  apl_core_if.bank  core
);

  apl_pkg::apl_pins_t next_latch;

  // One vector update, so every addressed pin moves in the same cycle
  always_comb begin
    next_latch = core.latch;
    next_latch = next_latch | core.setBits;
    next_latch = next_latch & ~core.clearBits;
    // Non-output pins are cleared by a toggle instead of inverted
    next_latch = (next_latch & ~core.toggleBits) | (~core.latch & core.dir & core.toggleBits);
    next_latch = next_latch & `APL_PIN_MASK;
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      core.latch <= `APL_PIN_RST;
    end else begin
      core.latch <= next_latch; // [R3] [R4] [R5] [R6] [R7] [R11] [R1]
    end
  end

endmodule : apl_pin_latch

// ---- core/apl_irq_select.sv ----
`include "apl_map.svh"

module apl_irq_select (
  input  wire logic clk_sys,
  input  wire logic rst_b,
  apl_core_if.sel   core
);

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      core.selVal <= {`APL_SEL_N{`APL_SEL_RST}}; // [R8]
    end else begin
      for (int i = 0; i < `APL_SEL_N; i++) begin
        if (core.selWr[i]) begin
          core.selVal[i] <= core.selData; // [R8]
        end
      end
    end
  end

endmodule : apl_irq_select

// ---- core/apl_top.sv ----
`include "apl_map.svh"

// Contract
// [R1] Action registers: only pins 2,4,6,10,12,14 exist
// [R2] Action registers ignore zeros, always read zero
// [R3] Set bit forces latch high, driven if output
// [R4] Set on non-output pin: latch high, undriven
// [R5] Clear bit forces latch low, undriven if input
// [R6] Toggle bit inverts latch on output pins
// [R7] Toggle on non-output pin clears the latch
// [R8] Select register: 5-bit field, upper bits zero
// [R9] Select value picks port A pin 0..31
// [R10] Select writes need protected write enable
// [R11] Multi-bit action write updates pins together
module apl_top (
  input  wire  logic                  clk_sys,
  input  wire  logic                  rst_b,
  input  wire  logic [7:0]            wb_adr_i,
  input  wire  logic [31:0]           wb_dat_i,
  output logic       [31:0]           wb_dat_o,
  input  wire  logic                  wb_we_i,
  input  wire  logic [3:0]            wb_sel_i,
  input  wire  logic                  wb_cyc_i,
  input  wire  logic                  wb_stb_i,
  output logic                        wb_ack_o,
  output logic       [`APL_PIN_W-1:0] pinOut,
  output logic       [`APL_PIN_W-1:0] pinOe,
  input  wire  logic [31:0]           portAIn,
  output logic       [`APL_SEL_N-1:0] extIrqLine
);

  // Reset release through two flops
  logic rstMeta_b;
  logic rstSync_b;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rstMeta_b <= 1'b0;
      rstSync_b <= 1'b0;
    end else begin
      rstMeta_b <= 1'b1;
      rstSync_b <= rstMeta_b;
    end
  end

  apl_core_if core ();

  apl_pin_latch u_latch (
    .clk_sys (clk_sys),
    .rst_b   (rstSync_b),
    .core    (core.bank)
  );

  apl_irq_select u_sel (
    .clk_sys (clk_sys),
    .rst_b   (rstSync_b),
    .core    (core.sel)
  );

  function automatic logic [31:0] apl_lane_mask(input logic [3:0] sel);
    logic [31:0] m;
    m = `APL_WORD_ZERO;
    for (int b = 0; b < 4; b++) begin
      m[b*`APL_LANE_W +: `APL_LANE_W] = {`APL_LANE_W{sel[b]}};
    end
    return m;
  endfunction : apl_lane_mask

  function automatic logic [31:0] apl_widen(input logic [`APL_PIN_W-1:0] v);
    return {{(32-`APL_PIN_W){1'b0}}, v};
  endfunction : apl_widen

  // Bus slave state
  apl_pkg::apl_bus_state_t state;
  apl_pkg::apl_bus_state_t next_state;
  logic                    request;
  logic                    wrAck;
  logic [5:0]              adrWord;
  logic [31:0]             wrMasked;
  apl_pkg::apl_pins_t      wrBits;
  logic [31:0]             next_rdData;

  assign request  = wb_cyc_i & wb_stb_i;
  assign adrWord  = wb_adr_i[7:2];
  assign wrMasked = wb_dat_i & apl_lane_mask(wb_sel_i);
  assign wrBits   = wrMasked[`APL_PIN_W-1:0] & `APL_PIN_MASK; // [R1]
  assign wrAck    = (state == apl_pkg::APL_BUS_ACK) & wb_we_i;
  assign wb_ack_o = (state == apl_pkg::APL_BUS_ACK);

  always_comb begin
    next_state = state;
    unique case (state)
      apl_pkg::APL_BUS_IDLE: begin
        if (request) begin
          next_state = apl_pkg::APL_BUS_ACK;
        end
      end
      apl_pkg::APL_BUS_ACK: begin
        next_state = apl_pkg::APL_BUS_IDLE;
      end
      default: begin
        next_state = apl_pkg::APL_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstSync_b) begin
    if (!rstSync_b) begin
      state <= apl_pkg::APL_BUS_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Software-owned configuration
  apl_pkg::apl_pins_t dirReg;
  logic               protEn;

  always_ff @(posedge clk_sys or negedge rstSync_b) begin
    if (!rstSync_b) begin
      dirReg <= `APL_PIN_RST;
    end else if (wrAck && adrWord == `APL_IDX_DIR) begin
      dirReg <= wrBits;
    end
  end

  always_ff @(posedge clk_sys or negedge rstSync_b) begin
    if (!rstSync_b) begin
      protEn <= 1'b0;
    end else if (wrAck && adrWord == `APL_IDX_PROT && wb_sel_i[0]) begin
      protEn <= wb_dat_i[`APL_PROT_BIT];
    end
  end

  // Action strobes last exactly the acknowledged write cycle
  always_comb begin
    core.setBits    = `APL_PIN_RST;
    core.clearBits  = `APL_PIN_RST;
    core.toggleBits = `APL_PIN_RST;
    if (wrAck) begin
      unique case (adrWord)
        `APL_IDX_SET:    core.setBits    = wrBits; // [R3] [R4] [R2]
        `APL_IDX_CLEAR:  core.clearBits  = wrBits; // [R5] [R2]
        `APL_IDX_TOGGLE: core.toggleBits = wrBits; // [R6] [R7] [R2]
        default: begin
          core.setBits = `APL_PIN_RST;
        end
      endcase
    end
  end

  assign core.dir     = dirReg;
  assign core.selData = wb_dat_i[`APL_SEL_W-1:0];

  // Select writes only land while the protected enable is set
  always_comb begin
    core.selWr = '0;
    if (wrAck && protEn && wb_sel_i[0]) begin // [R10]
      for (int i = 0; i < `APL_SEL_N; i++) begin
        if (adrWord == `APL_IDX_SEL0 + 6'(i)) begin
          core.selWr[i] = 1'b1;
        end
      end
    end
  end

  // Read data is captured when the request is taken
  always_comb begin
    next_rdData = `APL_WORD_ZERO;
    unique case (adrWord)
      `APL_IDX_DIR:   next_rdData = apl_widen(dirReg);
      `APL_IDX_LATCH: next_rdData = apl_widen(core.latch);
      `APL_IDX_PROT:  next_rdData[`APL_PROT_BIT] = protEn;
      `APL_IDX_SEL0:  next_rdData[`APL_SEL_W-1:0] = core.selVal[0]; // [R8]
      `APL_IDX_SEL1:  next_rdData[`APL_SEL_W-1:0] = core.selVal[1]; // [R8]
      `APL_IDX_SEL2:  next_rdData[`APL_SEL_W-1:0] = core.selVal[2]; // [R8]
      default: begin
        next_rdData = `APL_WORD_ZERO; // [R2]
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstSync_b) begin
    if (!rstSync_b) begin
      wb_dat_o <= `APL_WORD_ZERO;
    end else if (state == apl_pkg::APL_BUS_IDLE && request) begin
      wb_dat_o <= next_rdData;
    end
  end

  // Pin drive: the latch always follows writes, the pad only when output
  always_ff @(posedge clk_sys or negedge rstSync_b) begin
    if (!rstSync_b) begin
      pinOe <= `APL_PIN_RST;
    end else begin
      pinOe <= dirReg & `APL_PIN_MASK; // [R4] [R5] [R7]
    end
  end

  assign pinOut = core.latch; // [R3] [R5] [R6]

  // External interrupt lines follow the selected port A pin
  always_ff @(posedge clk_sys or negedge rstSync_b) begin
    if (!rstSync_b) begin
      extIrqLine <= '0;
    end else begin
      for (int i = 0; i < `APL_SEL_N; i++) begin
        extIrqLine[i] <= portAIn[core.selVal[i]]; // [R9]
      end
    end
  end

  // Checks
  property p_ack_single;
    @(posedge clk_sys) disable iff (!rstSync_b)
      wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_single: assert property (p_ack_single)
    else $error("ack held longer than one cycle");

  property p_ack_follows;
    @(posedge clk_sys) disable iff (!rstSync_b)
      (state == apl_pkg::APL_BUS_IDLE && request) |=> wb_ack_o;
  endproperty
  a_ack_follows: assert property (p_ack_follows)
    else $error("request not answered in one cycle");

  property p_action_reads_zero;
    @(posedge clk_sys) disable iff (!rstSync_b)
      (wb_ack_o && !wb_we_i && adrWord <= `APL_IDX_TOGGLE) |-> wb_dat_o == `APL_WORD_ZERO;
  endproperty
  a_action_reads_zero: assert property (p_action_reads_zero) // [R2]
    else $error("action register read nonzero");

  property p_reserved_zero;
    @(posedge clk_sys) disable iff (!rstSync_b)
      (core.latch & ~`APL_PIN_MASK) == `APL_PIN_RST && (pinOe & ~`APL_PIN_MASK) == `APL_PIN_RST;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) // [R1]
    else $error("unimplemented pin bit active");

  property p_set_high;
    @(posedge clk_sys) disable iff (!rstSync_b)
      (wrAck && adrWord == `APL_IDX_SET) |=>
        (core.latch & $past(wrBits)) == $past(wrBits);
  endproperty
  a_set_high: assert property (p_set_high) // [R3] [R4] [R11]
    else $error("set did not raise all addressed latches");

  property p_clear_low;
    @(posedge clk_sys) disable iff (!rstSync_b)
      (wrAck && adrWord == `APL_IDX_CLEAR) |=>
        (core.latch & $past(wrBits)) == `APL_PIN_RST;
  endproperty
  a_clear_low: assert property (p_clear_low) // [R5] [R11]
    else $error("clear did not lower all addressed latches");

  property p_toggle;
    @(posedge clk_sys) disable iff (!rstSync_b)
      (wrAck && adrWord == `APL_IDX_TOGGLE) |=>
        (core.latch & $past(wrBits)) == ($past(~core.latch & dirReg) & $past(wrBits));
  endproperty
  a_toggle: assert property (p_toggle) // [R6] [R7]
    else $error("toggle result wrong");

  property p_zero_write_keeps;
    @(posedge clk_sys) disable iff (!rstSync_b)
      (wrAck && adrWord <= `APL_IDX_TOGGLE) |=>
        (core.latch & ~$past(wrBits)) == ($past(core.latch) & ~$past(wrBits));
  endproperty
  a_zero_write_keeps: assert property (p_zero_write_keeps) // [R2]
    else $error("zero bit changed a latch");

  property p_undriven_input;
    @(posedge clk_sys) disable iff (!rstSync_b)
      ##1 (pinOe & ~$past(dirReg)) == `APL_PIN_RST;
  endproperty
  a_undriven_input: assert property (p_undriven_input) // [R4] [R5]
    else $error("non-output pin driven");

  property p_sel_protected;
    @(posedge clk_sys) disable iff (!rstSync_b)
      (wrAck && !protEn) |=> $stable(core.selVal);
  endproperty
  a_sel_protected: assert property (p_sel_protected) // [R10]
    else $error("select changed without protected enable");

  property p_sel_read;
    @(posedge clk_sys) disable iff (!rstSync_b)
      (wb_ack_o && !wb_we_i && adrWord >= `APL_IDX_SEL0 && adrWord <= `APL_IDX_SEL2) |->
        wb_dat_o[31:`APL_SEL_W] == '0;
  endproperty
  a_sel_read: assert property (p_sel_read) // [R8]
    else $error("select reserved bits nonzero");

  property p_irq_route;
    @(posedge clk_sys) disable iff (!rstSync_b)
      rstSync_b |=> extIrqLine[0] == $past(portAIn[core.selVal[0]]);
  endproperty
  a_irq_route: assert property (p_irq_route) // [R9]
    else $error("interrupt line not following selected pin");

  property p_irq_route_1;
    @(posedge clk_sys) disable iff (!rstSync_b)
      rstSync_b |=> extIrqLine[1] == $past(portAIn[core.selVal[1]]);
  endproperty
  a_irq_route_1: assert property (p_irq_route_1) // [R9]
    else $error("interrupt line 1 not following selected pin");

  property p_irq_route_2;
    @(posedge clk_sys) disable iff (!rstSync_b)
      rstSync_b |=> extIrqLine[2] == $past(portAIn[core.selVal[2]]);
  endproperty
  a_irq_route_2: assert property (p_irq_route_2) // [R9]
    else $error("interrupt line 2 not following selected pin");

  property p_sel_write;
    @(posedge clk_sys) disable iff (!rstSync_b)
      (wrAck && protEn && wb_sel_i[0] && adrWord == `APL_IDX_SEL0) |=>
        core.selVal[0] == $past(wb_dat_i[`APL_SEL_W-1:0]);
  endproperty
  a_sel_write: assert property (p_sel_write) // [R8] [R10]
    else $error("enabled select write did not land");

  property p_sel_lane;
    @(posedge clk_sys) disable iff (!rstSync_b)
      (wrAck && !wb_sel_i[0]) |=> $stable(core.selVal);
  endproperty
  a_sel_lane: assert property (p_sel_lane) // [R10]
    else $error("select changed without low byte lane");

  property p_latch_hold;
    @(posedge clk_sys) disable iff (!rstSync_b)
      !(wrAck && adrWord <= `APL_IDX_TOGGLE) |=> $stable(core.latch);
  endproperty
  a_latch_hold: assert property (p_latch_hold) // [R2]
    else $error("latch changed without action write");

  property p_ack_idle;
    @(posedge clk_sys) disable iff (!rstSync_b)
      (state == apl_pkg::APL_BUS_ACK || !request) |=> !wb_ack_o;
  endproperty
  a_ack_idle: assert property (p_ack_idle)
    else $error("ack without a taken request");

endmodule : apl_top

// ---- tb/apl_board.sv ----
`include "apl_map.svh"

module apl_board (
  input  wire logic                  clk_sys,
  input  wire logic [`APL_PIN_W-1:0] pinOut,
  input  wire logic [`APL_PIN_W-1:0] pinOe,
  output logic      [`APL_PIN_W-1:0] padLevel
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [`APL_PIN_W-1:0] floatBits = 15'h2A2A;
  // Undriven pads wander every cycle so a stale level cannot pass for a driven one
  always @(posedge clk_sys) begin
    floatBits <= ~floatBits;
  end
  always_comb padLevel = (pinOut & pinOe) | (floatBits & ~pinOe);
endmodule : apl_board

// ---- tb/apl_top_test.sv ----
`include "apl_map.svh"

module apl_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic                  clk_sys  = 1'b0;
  logic                  rst_b;
  logic [7:0]            wb_adr_i = 8'h00;
  logic [31:0]           wb_dat_i = 32'h0000_0000;
  logic                  wb_we_i  = 1'b0;
  logic [3:0]            wb_sel_i = 4'hF;
  logic                  wb_cyc_i = 1'b0;
  logic                  wb_stb_i = 1'b0;
  logic [31:0]           portAIn  = 32'h0000_0000;
  logic [31:0]           wb_dat_o;
  logic                  wb_ack_o;
  logic [`APL_PIN_W-1:0] pinOut;
  logic [`APL_PIN_W-1:0] pinOe;
  logic [`APL_PIN_W-1:0] padLevel;
  logic [`APL_SEL_N-1:0] extIrqLine;
  int                    n_mismatch = 0;
  int                    comparisons = 0;

  apl_top uut (.clk_sys(clk_sys), .rst_b(rst_b), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .pinOut(pinOut), .pinOe(pinOe),
    .portAIn(portAIn), .extIrqLine(extIrqLine));
  apl_board board (.clk_sys(clk_sys), .pinOut(pinOut), .pinOe(pinOe), .padLevel(padLevel));

  initial begin
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One classic cycle; leaves cyc/stb low for a full cycle before returning
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat, input logic [3:0] sel,
                    output logic [31:0] rd);
    int i;
    i = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    wb_sel_i <= sel;
    do begin
      @(posedge clk_sys);
      i++;
    end while (wb_ack_o !== 1'b1 && i < 20);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    if (wb_ack_o !== 1'b1) begin
      n_mismatch++;
      print_verdict();
    end else begin
      @(posedge clk_sys);
    end
  endtask : wb

  task automatic wr(input logic [7:0] adr, input logic [31:0] dat, input logic [3:0] sel = 4'hF);
    logic [31:0] d;
    wb(1'b1, adr, dat, sel, d);
  endtask : wr

  task automatic rdchk(input logic [7:0] adr, input logic [31:0] exp);
    logic [31:0] d;
    wb(1'b0, adr, 32'h0000_0000, 4'hF, d);
    chk(d, exp);
  endtask : rdchk

  task automatic settle;
    repeat (3) @(posedge clk_sys);
  endtask : settle

  task automatic t_reset;
    settle();
    chk(32'(pinOut), 32'h0000_0000);
    chk(32'(pinOe), 32'h0000_0000);
    for (int i = 0; i < 3; i++) rdchk(8'h20 + 8'(4 * i), 32'h0000_0000);
    for (int i = 0; i < 3; i++) rdchk(8'(4 * i), 32'h0000_0000);
    $display("test reset done");
  endtask : t_reset

  task automatic t_set;
    wr(8'h0C, 32'h0000_7FFF);
    wr(8'h00, 32'hFFFF_FFFF);
    settle();
    chk(32'(pinOut), 32'h0000_5454);
    chk(32'(padLevel & 15'h5454), 32'h0000_5454);
    rdchk(8'h00, 32'h0000_0000);
    $display("test set done");
  endtask : t_set

  task automatic t_clear_toggle;
    wr(8'h04, 32'h0000_0014);
    settle();
    chk(32'(pinOut), 32'h0000_5440);
    wr(8'h08, 32'h0000_5454);
    settle();
    chk(32'(pinOut), 32'h0000_0014);
    rdchk(8'h04, 32'h0000_0000);
    rdchk(8'h08, 32'h0000_0000);
    $display("test clear_toggle done");
  endtask : t_clear_toggle

  task automatic t_input_pins;
    wr(8'h0C, 32'h0000_0004);
    wr(8'h00, 32'h0000_5454);
    settle();
    chk(32'(pinOe), 32'h0000_0004);
    chk(32'(pinOut), 32'h0000_5454);
    wr(8'h08, 32'h0000_0050);
    settle();
    chk(32'(pinOut), 32'h0000_5404);
    // Latch bits 4 and 6 now low on input pins: an inversion would raise them
    wr(8'h08, 32'h0000_0050);
    settle();
    chk(32'(pinOut), 32'h0000_5404);
    wr(8'h04, 32'h0000_0004);
    settle();
    chk(32'(padLevel & 15'h0004), 32'h0000_0000);
    $display("test input_pins done");
  endtask : t_input_pins

  task automatic t_byte_lanes;
    wr(8'h04, 32'hFFFF_FFFF, 4'h2);
    wr(8'h00, 32'hFFFF_FFFF, 4'h1);
    settle();
    chk(32'(pinOut), 32'h0000_0054);
    rdchk(8'h10, 32'h0000_0054);
    rdchk(8'h0C, 32'h0000_0004);
    wr(8'h14, 32'h0000_0001, 4'hE);
    wr(8'h20, 32'h0000_0007);
    rdchk(8'h20, 32'h0000_0000);
    $display("test byte_lanes done");
  endtask : t_byte_lanes

  task automatic t_select;
    logic [31:0] pat [2] = '{32'h8000_0000, 32'h0000_0021};
    wr(8'h20, 32'h0000_0005);
    rdchk(8'h20, 32'h0000_0000);
    wr(8'h14, 32'h0000_0001);
    wr(8'h20, 32'hFFFF_FFFF);
    wr(8'h24, 32'h0000_0005);
    rdchk(8'h20, 32'h0000_001F);
    rdchk(8'h24, 32'h0000_0005);
    rdchk(8'h3C, 32'h0000_0000);
    for (int i = 0; i < 2; i++) begin
      portAIn <= pat[i];
      settle();
      chk(32'(extIrqLine), {29'h0, pat[i][0], pat[i][5], pat[i][31]});
    end
    wr(8'h14, 32'h0000_0000);
    wr(8'h24, 32'h0000_001F);
    rdchk(8'h24, 32'h0000_0005);
    $display("test select done");
  endtask : t_select

  task automatic t_reset_mid;
    rst_b <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk_sys);
    chk(32'(pinOut), 32'h0000_0000);
    chk(32'(pinOe), 32'h0000_0000);
    chk(32'(extIrqLine), 32'h0000_0007);
    rdchk(8'h24, 32'h0000_0000);
    $display("test reset_mid done");
  endtask : t_reset_mid

  initial begin
    rst_b <= 1'b0;
    repeat (12) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk_sys);
    t_reset();
    t_set();
    t_clear_toggle();
    t_input_pins();
    t_byte_lanes();
    t_select();
    t_reset_mid();
    print_verdict();
  end
endmodule : apl_top_test
